// ===== pia_pkg.sv
// Summary of operation
// - user parameter writes are allowed only while the lock word holds 0x1235.
// - writing any other value to the lock word restores write protection.
// - lock word reads back the key when unlocked, zero when protected.
// - feature_select word 32 holds module-specific operating-mode bits.
// - command bit 7 set routes the data word to parameter access.
// - command bit 6 picks direction: 0 reads unchanged, 1 writes data word.
// - command bits 5..0 select one of 64 registers.
// - acknowledge sets bit 7 and echoes the accessed index in bits 5..0.
// - acknowledge byte is read-only; command byte can be read back.
// - acknowledge bit 6 always reads 0, also after writes.
// - data word ignored on reads; carries the value on writes.
// - read value returned as 16-bit word, high byte first.
// - word 8 returns the module type identifier.
// - some settings act only after the next power-up reset.
// - words 33..47 type-specific, 48..63 reserved for extensions.
// - every logical channel owns its own 64-word parameter area.
// - words 8..15 are fixed and can be read but never changed.
package pia_pkg;
    localparam int unsigned IDX_W        = 6;
    localparam int unsigned DATA_W       = 16;
    localparam int unsigned ACCESS_BIT   = 7;
    localparam int unsigned WRITE_BIT    = 6;
    localparam int unsigned ACK_BIT      = 7;
    localparam logic [15:0] UNLOCK_KEY   = 16'h1235;
    localparam logic [15:0] LOCKED_VALUE = 16'h0000;
    localparam logic [15:0] ZERO_WORD    = 16'h0000;
    localparam logic [7:0]  IDLE_CMD     = 8'h00;
    localparam logic [7:0]  IDLE_ACK     = 8'h00;
    localparam logic [5:0]  PROC_LAST    = 6'h07;
    localparam logic [5:0]  ROM_FIRST    = 6'h08;
    localparam logic [5:0]  ROM_LAST     = 6'h0F;
    localparam logic [5:0]  TYPE_ID_IDX  = 6'h08;
    localparam logic [5:0]  SW_VER_IDX   = 6'h09;
    localparam logic [5:0]  UNLOCK_IDX   = 6'h1F;
    localparam logic [5:0]  FEATURE_IDX  = 6'h20;

    typedef struct packed {
        logic [7:0]  cmd;
        logic [15:0] data;
    } out_image_t;

    typedef struct packed {
        logic [7:0]  ack;
        logic [15:0] data;
    } in_image_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h1,
        ST_READ   = 3'h2,
        ST_ANSWER = 3'h4
    } acc_state_t;
endpackage

// ===== pia_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser plus one compare stage for a multi-bit image
module pia_sync #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout,
    output logic              stable
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_d;
    logic [W-1:0] s3_d;

    // bytes of the image may land on different edges, so act only on a value seen twice
    always_comb begin
        s1_d = din;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    assign dout   = s3_q;
    assign stable = (s2_q == s3_q);
endmodule

// ===== pia_param_mem.sv
`timescale 1ns/100ps
// parameter word store, one write port, registered read port
module pia_param_mem #(
    parameter int unsigned AW = 8,
    parameter int unsigned DW = 16
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rdata_q;

    // array has no reset so it maps onto plain ram
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

    assign rdata = rdata_q;
endmodule

// ===== process_image_param_access.sv
`timescale 1ns/100ps
// indirect parameter access behind the cyclic process image
module process_image_param_access #(
    parameter int unsigned CHAN_W     = 2,
    parameter int unsigned CHANNELS   = 1 << CHAN_W,
    parameter logic [15:0] TYPE_ID    = 16'h0001, // arbitrary value, set per product
    parameter logic [15:0] SW_VERSION = 16'h0101  // arbitrary value, set per product
) (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire pia_pkg::out_image_t        out_image,
    input  wire logic [CHAN_W-1:0]          chan_sel,
    input  wire logic [15:0]                proc_in,
    input  wire logic [CHANNELS-1:0][15:0]  feature_boot,
    output pia_pkg::in_image_t              in_image,
    output logic      [7:0]                 cmd_readback,
    output logic      [15:0]                proc_out,
    output logic      [CHANNELS-1:0]        write_enabled,
    output logic      [CHANNELS-1:0][15:0]  feature_store,
    output logic      [CHANNELS-1:0][15:0]  feature_active
);
    localparam int unsigned IMG_W = CHAN_W + 24;
    localparam int unsigned MEM_AW = CHAN_W + pia_pkg::IDX_W;

    // synchronised image
    logic [IMG_W-1:0]       img_raw;
    logic                   img_stable;
    pia_pkg::out_image_t    img;
    logic [CHAN_W-1:0]      img_ch;
    logic [5:0]             img_idx;

    // access state
    pia_pkg::acc_state_t    st_q;
    pia_pkg::acc_state_t    st_d;
    pia_pkg::out_image_t    pend_q;
    pia_pkg::out_image_t    pend_d;
    logic [CHAN_W-1:0]      pch_q;
    logic [CHAN_W-1:0]      pch_d;
    logic [7:0]             last_q;
    logic [7:0]             last_d;
    pia_pkg::in_image_t     ans_q;
    pia_pkg::in_image_t     ans_d;
    logic [15:0]            pout_q;
    logic [15:0]            pout_d;
    logic [7:0]             rb_q;
    logic [7:0]             rb_d;
    logic                   boot_q;
    logic                   boot_d;

    // decode and datapath
    logic                   take;
    logic                   take_wr;
    logic                   wr_allowed;
    logic                   mem_we;
    logic                   wr_lock;
    logic                   wr_feat;
    logic [5:0]             pidx;
    logic [15:0]            mem_rdata;
    logic [15:0]            rd_val;
    logic [CHANNELS-1:0]    unl_vec;
    logic [15:0]            feat_vec [CHANNELS];

    // channel crosses with the command, so a channel change cannot split from it
    pia_sync #(
        .W      (IMG_W)
    ) u_sync (
        .clk    (clk),
        .nrst   (nrst),
        .din    ({chan_sel, out_image}),
        .dout   (img_raw),
        .stable (img_stable)
    );

    // split the synchronised word back into image and channel
    assign img     = img_raw[23:0];
    assign img_ch  = img_raw[IMG_W-1:24];
    assign img_idx = img.cmd[5:0];
    assign pidx    = pend_q.cmd[5:0];

    // per-channel area, indexed by channel then word
    pia_param_mem #(
        .AW    (MEM_AW),
        .DW    (pia_pkg::DATA_W)
    ) u_mem (
        .clk   (clk),
        .nrst  (nrst),
        .we    (mem_we),
        .waddr ({img_ch, img_idx}),
        .wdata (img.data),
        .raddr ({pch_q, pidx}),
        .rdata (mem_rdata)
    );

    // write decode: words 0..7 free, 8..15 fixed, lock word always, rest needs the key
    // a refused write is still taken, so it gets the same answer as any other
    always_comb begin
        take_wr    = take && img.cmd[pia_pkg::WRITE_BIT];
        wr_allowed = 1'h0;
        if (img_idx <= pia_pkg::PROC_LAST) begin
            wr_allowed = 1'h1;
        end else if (img_idx >= pia_pkg::ROM_FIRST && img_idx <= pia_pkg::ROM_LAST) begin
            wr_allowed = 1'h0;
        end else if (img_idx == pia_pkg::UNLOCK_IDX) begin
            wr_allowed = 1'h1;
        end else begin
            wr_allowed = unl_vec[img_ch];
        end
        wr_lock = take_wr && (img_idx == pia_pkg::UNLOCK_IDX);
        wr_feat = take_wr && wr_allowed && (img_idx == pia_pkg::FEATURE_IDX);
        // words 0..7 and 16..63 apart from lock and feature live in ram
        mem_we  = take_wr && wr_allowed && !wr_lock
                  && (img_idx != pia_pkg::FEATURE_IDX);
    end

    // lock word and feature word per channel
    generate
        for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
            logic        unl_q;
            logic        unl_d;
            logic [15:0] feat_q;
            logic [15:0] feat_d;
            logic [15:0] act_q;
            logic [15:0] act_d;

            // only the stored form of the feature word changes on write; the active copy
            // is taken once after reset, since modes cannot switch safely while running
            always_comb begin
                unl_d  = unl_q;
                feat_d = feat_q;
                act_d  = act_q;
                if (!boot_q) begin
                    feat_d = feature_boot[g];
                    act_d  = feature_boot[g];
                end else begin
                    if (wr_lock && img_ch == CHAN_W'(g)) begin
                        unl_d = (img.data == pia_pkg::UNLOCK_KEY);
                    end
                    if (wr_feat && img_ch == CHAN_W'(g)) begin
                        feat_d = img.data;
                    end
                end
            end

            // lock starts closed after every reset, so a power cycle always relocks
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    unl_q  <= 1'h0;
                    feat_q <= pia_pkg::ZERO_WORD;
                    act_q  <= pia_pkg::ZERO_WORD;
                end else begin
                    unl_q  <= unl_d;
                    feat_q <= feat_d;
                    act_q  <= act_d;
                end
            end

            assign unl_vec[g]        = unl_q;
            assign feat_vec[g]       = feat_q;
            assign feature_store[g]  = feat_q;
            assign feature_active[g] = act_q;
        end
    endgenerate

    // read value of the pending word
    // words 10..15 hold nothing in this block and read as zero
    always_comb begin
        rd_val = mem_rdata;
        if (pidx == pia_pkg::TYPE_ID_IDX) begin
            rd_val = TYPE_ID;
        end else if (pidx == pia_pkg::SW_VER_IDX) begin
            rd_val = SW_VERSION;
        end else if (pidx >= pia_pkg::ROM_FIRST && pidx <= pia_pkg::ROM_LAST) begin
            rd_val = pia_pkg::ZERO_WORD;
        end else if (pidx == pia_pkg::UNLOCK_IDX) begin
            rd_val = unl_vec[pch_q] ? pia_pkg::UNLOCK_KEY : pia_pkg::LOCKED_VALUE;
        end else if (pidx == pia_pkg::FEATURE_IDX) begin
            rd_val = feat_vec[pch_q];
        end
    end

    // access sequencer: take, read back (after any write), answer
    always_comb begin
        st_d   = st_q;
        pend_d = pend_q;
        pch_d  = pch_q;
        last_d = last_q;
        ans_d  = ans_q;
        pout_d = pout_q;
        rb_d   = rb_q;
        boot_d = 1'h1;
        take   = 1'h0;
        if (img_stable) begin
            rb_d = img.cmd;
        end
        case (st_q)
            pia_pkg::ST_IDLE: begin
                if (img_stable && !img.cmd[pia_pkg::ACCESS_BIT]) begin
                    // process data mode: word flows straight through
                    last_d     = img.cmd;
                    pout_d     = img.data;
                    ans_d.ack  = pia_pkg::IDLE_ACK;
                    ans_d.data = proc_in;
                end else if (img_stable && img.cmd != last_q) begin
                    take   = 1'h1;
                    last_d = img.cmd;
                    pend_d = img;
                    pch_d  = img_ch;
                    st_d   = pia_pkg::ST_READ;
                end
            end
            pia_pkg::ST_READ: begin
                // ram read port shows a write made at the take edge one cycle later
                st_d = pia_pkg::ST_ANSWER;
            end
            pia_pkg::ST_ANSWER: begin
                // read-back value goes out, so a refused write shows the old word
                ans_d.ack  = {1'h1, 1'h0, pidx};
                ans_d.data = rd_val;
                st_d       = pia_pkg::ST_IDLE;
            end
            default: begin
                st_d = pia_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q   <= pia_pkg::ST_IDLE;
            pend_q <= '0;
            pch_q  <= '0;
            last_q <= pia_pkg::IDLE_CMD;
            ans_q  <= '0;
            pout_q <= pia_pkg::ZERO_WORD;
            rb_q   <= pia_pkg::IDLE_CMD;
            boot_q <= 1'h0;
        end else begin
            st_q   <= st_d;
            pend_q <= pend_d;
            pch_q  <= pch_d;
            last_q <= last_d;
            ans_q  <= ans_d;
            pout_q <= pout_d;
            rb_q   <= rb_d;
            boot_q <= boot_d;
        end
    end

    // every output leaves straight from a register
    assign in_image      = ans_q;
    assign cmd_readback  = rb_q;
    assign proc_out      = pout_q;
    assign write_enabled = unl_vec;

    // checks: answer shape and timing
    a_ack_flag_set: assert property (@(posedge clk) disable iff (!nrst)
        st_q == pia_pkg::ST_ANSWER |=> in_image.ack[7] && in_image.ack[5:0] == $past(pidx))
        else $error("acknowledge flag or index wrong");

    a_ack_bit_six: assert property (@(posedge clk) disable iff (!nrst)
        in_image.ack[6] == 1'h0)
        else $error("acknowledge bit 6 set");

    a_answer_delay: assert property (@(posedge clk) disable iff (!nrst)
        take |=> !take ##1 (st_q == pia_pkg::ST_ANSWER) ##1 in_image.ack[7])
        else $error("answer not three cycles after take");

    a_answer_hold: assert property (@(posedge clk) disable iff (!nrst)
        st_q == pia_pkg::ST_IDLE && !take && last_q[7] && $past(st_q) == pia_pkg::ST_IDLE
        && !(img_stable && !img.cmd[pia_pkg::ACCESS_BIT]) // idle command ends the hold
        |=> $stable(in_image))
        else $error("answer changed without new command");

    // checks: lock, protection and storage
    a_lock_follows: assert property (@(posedge clk) disable iff (!nrst)
        wr_lock && boot_q |=> unl_vec[$past(img_ch)] == ($past(img.data) == pia_pkg::UNLOCK_KEY))
        else $error("lock state does not follow written key");

    a_locked_read_zero: assert property (@(posedge clk) disable iff (!nrst)
        st_q == pia_pkg::ST_ANSWER && pidx == pia_pkg::UNLOCK_IDX
        |=> in_image.data == ($past(unl_vec[pch_q]) ? pia_pkg::UNLOCK_KEY : 16'h0000))
        else $error("lock word read value wrong");

    a_rom_no_write: assert property (@(posedge clk) disable iff (!nrst)
        mem_we |-> !(img_idx >= pia_pkg::ROM_FIRST && img_idx <= pia_pkg::ROM_LAST))
        else $error("write reached fixed area");

    a_protect_hold: assert property (@(posedge clk) disable iff (!nrst)
        (mem_we || wr_feat) && img_idx > pia_pkg::ROM_LAST |-> unl_vec[img_ch])
        else $error("protected word written while locked");

    a_read_no_store: assert property (@(posedge clk) disable iff (!nrst)
        take && !img.cmd[6] |-> !mem_we && !wr_lock && !wr_feat)
        else $error("read command changed storage");

    a_active_frozen: assert property (@(posedge clk) disable iff (!nrst)
        boot_q |=> $stable(feature_active))
        else $error("active feature word changed while running");

    a_relock_key: assert property (@(posedge clk) disable iff (!nrst)
        wr_lock && boot_q && img.data != pia_pkg::UNLOCK_KEY
        |=> !unl_vec[$past(img_ch)])
        else $error("lock stayed open after a wrong key");

    a_lock_own_chan: assert property (@(posedge clk) disable iff (!nrst)
        wr_lock && boot_q
        |=> ((unl_vec ^ $past(unl_vec)) & ~(CHANNELS'(1) << $past(img_ch))) == '0)
        else $error("lock write reached another channel");

    a_feature_write: assert property (@(posedge clk) disable iff (!nrst)
        wr_feat && boot_q |=> feature_store[$past(img_ch)] == $past(img.data))
        else $error("feature word not stored");

    // checks: pass-through, read back and boot load
    a_type_id_word: assert property (@(posedge clk) disable iff (!nrst)
        st_q == pia_pkg::ST_ANSWER && pidx == pia_pkg::TYPE_ID_IDX
        |=> in_image.data == TYPE_ID)
        else $error("type identifier read wrong");

    a_process_pass: assert property (@(posedge clk) disable iff (!nrst)
        st_q == pia_pkg::ST_IDLE && img_stable && !img.cmd[pia_pkg::ACCESS_BIT]
        |=> proc_out == $past(img.data) && in_image.ack == pia_pkg::IDLE_ACK
            && in_image.data == $past(proc_in))
        else $error("process word not passed through");

    a_readback_copy: assert property (@(posedge clk) disable iff (!nrst)
        img_stable |=> cmd_readback == $past(img.cmd))
        else $error("command byte read back wrong");

    a_repeat_ignored: assert property (@(posedge clk) disable iff (!nrst)
        img_stable && img.cmd == last_q |-> !take)
        else $error("repeated command executed again");

    a_boot_load: assert property (@(posedge clk) disable iff (!nrst)
        !boot_q |=> feature_active == $past(feature_boot)
            && feature_store == $past(feature_boot))
        else $error("feature words not loaded after reset");

    // scenarios worth seeing in a run
    c_write_taken: cover property (@(posedge clk) disable iff (!nrst) take_wr && mem_we);
    c_unlock_seen: cover property (@(posedge clk) disable iff (!nrst)
        wr_lock && img.data == pia_pkg::UNLOCK_KEY);
    c_locked_write: cover property (@(posedge clk) disable iff (!nrst)
        take_wr && !wr_allowed);
    c_type_read: cover property (@(posedge clk) disable iff (!nrst)
        st_q == pia_pkg::ST_ANSWER && pidx == pia_pkg::TYPE_ID_IDX);
    c_process_mode: cover property (@(posedge clk) disable iff (!nrst)
        st_q == pia_pkg::ST_IDLE && img_stable && !img.cmd[pia_pkg::ACCESS_BIT]);
endmodule

// ===== pia_ctrl_model.sv
`timescale 1ns/100ps
// behavioural controller on the far side of the process image
module pia_ctrl_model (
    input  wire logic           clk,
    output pia_pkg::out_image_t out_image,
    output logic [1:0]          chan_sel
);
    initial begin
        out_image = '0;
        chan_sel  = '0;
    end

    // hold each command well past sync plus answer time, then fall back to
    // the idle command so the next request is always a new byte value
    task automatic send(input logic [7:0] cmd, input logic [15:0] data, input logic [1:0] chan);
        @(negedge clk);
        out_image.cmd  <= cmd;
        out_image.data <= data;
        chan_sel       <= chan;
        repeat (10) @(negedge clk);
        out_image.cmd  <= pia_pkg::IDLE_CMD;
        out_image.data <= ~data; // a released word must not keep its old value
        repeat (8) @(negedge clk);
    endtask
endmodule

// ===== test_process_image_param_access.sv
`timescale 1ns/100ps
module test_process_image_param_access;
    localparam logic [15:0] TYPE_ID = 16'h5A31; // arbitrary value
    localparam logic [15:0] SW_VER  = 16'h0203; // arbitrary value

    logic                clk;
    logic                nrst;
    pia_pkg::out_image_t out_image;
    pia_pkg::in_image_t  in_image;
    logic [1:0]          chan_sel;
    logic [15:0]         proc_in;
    logic [15:0]         proc_out;
    logic [3:0][15:0]    feature_boot;
    logic [3:0][15:0]    feature_store;
    logic [3:0][15:0]    feature_active;
    logic [3:0]          write_enabled;
    logic [7:0]          cmd_readback;
    logic [7:0]          prev_ack;
    pia_pkg::in_image_t  exp_q[$];
    logic [7:0]          cmd_q[$];
    int                  fails;
    int                  checks;
    int                  cyc;
    logic [1:0]          ch;
    logic [15:0]         v;
    logic [15:0]         w;

    process_image_param_access #(
        .TYPE_ID    (TYPE_ID),
        .SW_VERSION (SW_VER)
    ) u_dut (
        .clk            (clk),
        .nrst           (nrst),
        .out_image      (out_image),
        .chan_sel       (chan_sel),
        .proc_in        (proc_in),
        .feature_boot   (feature_boot),
        .in_image       (in_image),
        .cmd_readback   (cmd_readback),
        .proc_out       (proc_out),
        .write_enabled  (write_enabled),
        .feature_store  (feature_store),
        .feature_active (feature_active)
    );

    pia_ctrl_model u_model (
        .clk       (clk),
        .out_image (out_image),
        .chan_sel  (chan_sel)
    );

    always #25 clk = ~clk;

    function automatic logic [15:0] rnd();
        return 16'($urandom);
    endfunction

    task automatic give_verdict();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmp_img(input pia_pkg::in_image_t got, input pia_pkg::in_image_t exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // note the expected answer, then let the controller model send it
    task automatic acc(input logic [7:0] cmd, input logic [15:0] data, input logic [15:0] exp_d);
        pia_pkg::in_image_t e;
        e = {1'b1, 1'b0, cmd[5:0], exp_d};
        exp_q.push_back(e);
        cmd_q.push_back(cmd);
        u_model.send(cmd, data, ch);
    endtask

    // each fresh acknowledge consumes the oldest note
    always @(negedge clk) begin
        if (nrst && in_image.ack[7] === 1'b1 && prev_ack[7] !== 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, in_image, 24'h000000);
            end else begin
                cmp_img(in_image, exp_q.pop_front());
                cmp_word({8'h00, cmd_readback}, {8'h00, cmd_q.pop_front()});
            end
        end
        prev_ack <= in_image.ack;
    end

    // hang guard: the whole sequence needs about 2300 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(39));
        clk      = 1'b0;
        nrst     = 1'b0;
        fails    = 0;
        checks   = 0;
        cyc      = 0;
        prev_ack = 8'h00;
        proc_in  = rnd();
        ch       = 2'($urandom_range(3));
        for (int i = 0; i < 4; i++) begin
            feature_boot[i] = rnd();
        end
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        acc(8'h88, rnd(), TYPE_ID);
        acc(8'hC9, rnd(), SW_VER);
        $display("test fixed words done");
        v = rnd();
        acc(8'h9F, rnd(), 16'h0000);
        acc(8'hE0, v, feature_boot[ch]);
        acc(8'hDF, 16'h1235, 16'h1235);
        cmp_word({12'h000, write_enabled}, 16'h0001 << ch);
        acc(8'hE0, v, v);
        acc(8'hA0, rnd(), v);
        cmp_word(feature_store[ch], v);
        cmp_word(feature_active[ch], feature_boot[ch]);
        // every writable index except lock and feature words, data word random on the read-back
        for (int i = 0; i < 64; i++) begin
            if ((i < 8 || i > 15) && i != 31 && i != 32) begin
                w = rnd();
                acc({2'b11, 6'(i)}, w, w);
                acc({2'b10, 6'(i)}, rnd(), w);
            end
        end
        ch = ch ^ 2'b01;
        acc(8'hE0, ~v, feature_boot[ch]);
        ch = ch ^ 2'b01;
        acc(8'hDF, 16'h1236, 16'h0000);
        cmp_word({12'h000, write_enabled}, 16'h0000);
        acc(8'hE0, ~v, v);
        acc(8'hDF, 16'h0000, 16'h0000);
        $display("test lock and store done");
        // process mode: command bit 7 clear passes the words straight on
        v = rnd();
        fork
            u_model.send(8'h35, v, ch);
        join_none
        repeat (8) @(negedge clk);
        cmp_word(proc_out, v);
        cmp_img(in_image, {8'h00, proc_in});
        repeat (12) @(negedge clk);
        $display("test process mode done");
        cmp_word(16'(exp_q.size()), 16'h0000);
        give_verdict();
    end
endmodule
